// *** rtl/dphw_host.sv ***
// Host controller driving the converter parallel port
`timescale 1ns/1ps
module dphw_host (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire dphw_pkg::dphw_req_t req_i,
    input wire logic sync_mode_i,
    input wire logic correction_enable_i,
    output logic rsp_valid_o,
    output logic [dphw_pkg::DATA_W-1:0] rsp_data_o,
    output dphw_pkg::dphw_pins_t pins_o,
    input wire logic [dphw_pkg::DATA_W-1:0] data_i,
    input wire logic busy_i
);
    // ==========================================================
    // Pin input synchronisers
    logic [dphw_pkg::DATA_W:0] pin_s;
    logic [dphw_pkg::DATA_W-1:0] din_s;
    logic busy_s;

    dphw_sync #(.W(dphw_pkg::DATA_W + 1)) u_sync (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .d_i({busy_i, data_i}),
        .q_o(pin_s)
    );
    assign din_s = pin_s[dphw_pkg::DATA_W-1:0];
    assign busy_s = pin_s[dphw_pkg::DATA_W];

    // ==========================================================
    // Access sequencer
    dphw_pkg::dphw_state_t st_q, st_d;
    logic [dphw_pkg::CNT_W-1:0] cnt_q, cnt_d;
    dphw_pkg::dphw_req_t cur_q, cur_d;
    dphw_pkg::dphw_pins_t pins_q, pins_d;
    logic rsp_valid_q, rsp_valid_d;
    logic [dphw_pkg::DATA_W-1:0] rsp_data_q, rsp_data_d;
    logic need_load;

    // Channel writes in synchronous mode need a trigger
    assign need_load = !cur_q.read && cur_q.chan_reg && sync_mode_i;
    assign req_ready_o = (st_q == dphw_pkg::ST_IDLE);

    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        cur_d = cur_q;
        pins_d = pins_q;
        rsp_valid_d = 1'b0;
        rsp_data_d = rsp_data_q;
        // Async mode keeps the strobe low so writes land directly
        pins_d.load_strobe_n = sync_mode_i ? pins_q.load_strobe_n : 1'b0;
        case (st_q)
            dphw_pkg::ST_IDLE:
            begin
                if (sync_mode_i)
                begin
                    pins_d.load_strobe_n = 1'b1;
                end
                if (req_valid_i)
                begin
                    cur_d = req_i;
                    pins_d.addr = req_i.addr;
                    pins_d.rd_nwr = req_i.read;
                    pins_d.dout = req_i.wdata;
                    pins_d.data_oe_n = req_i.read;
                    cnt_d = dphw_pkg::CNT_W'(dphw_pkg::DIR_SETUP_CYC);
                    st_d = dphw_pkg::ST_DIR;
                end
            end
            dphw_pkg::ST_DIR:
            begin
                if (cnt_q > 1)
                begin
                    cnt_d = cnt_q - 1'b1;
                end
                else
                begin
                    pins_d.sel_n = 1'b0;
                    cnt_d = cur_q.read ? dphw_pkg::CNT_W'(dphw_pkg::RD_SEL_CYC + 2)
                                       : dphw_pkg::CNT_W'(dphw_pkg::WR_SEL_CYC);
                    st_d = dphw_pkg::ST_SEL;
                end
            end
            dphw_pkg::ST_SEL:
            begin
                // Read select covers the two-flop delay on returned data
                if (cnt_q > 1)
                begin
                    cnt_d = cnt_q - 1'b1;
                end
                else
                begin
                    if (cur_q.read)
                    begin
                        rsp_data_d = din_s;
                        rsp_valid_d = 1'b1;
                    end
                    pins_d.sel_n = 1'b1;
                    cnt_d = dphw_pkg::CNT_W'(dphw_pkg::SEL_TO_LOAD_CYC);
                    st_d = dphw_pkg::ST_HOLD;
                end
            end
            dphw_pkg::ST_HOLD:
            begin
                // Data and direction hold past select rising; gap also meets load spacing
                if (cnt_q > 1)
                begin
                    cnt_d = cnt_q - 1'b1;
                end
                else
                begin
                    pins_d.data_oe_n = 1'b1;
                    pins_d.rd_nwr = 1'b1;
                    if (need_load && correction_enable_i)
                    begin
                        cnt_d = dphw_pkg::CNT_W'(dphw_pkg::BUSY_FALL_CYC + 2);
                        st_d = dphw_pkg::ST_BUSY;
                    end
                    else if (need_load)
                    begin
                        pins_d.load_strobe_n = 1'b0;
                        cnt_d = dphw_pkg::CNT_W'(dphw_pkg::LOAD_PULSE_CYC);
                        st_d = dphw_pkg::ST_LOAD;
                    end
                    else
                    begin
                        st_d = dphw_pkg::ST_IDLE;
                    end
                end
            end
            dphw_pkg::ST_BUSY:
            begin
                // Busy may rise late; wait its fall window, then for it to clear
                if (cnt_q > 0)
                begin
                    cnt_d = cnt_q - 1'b1;
                end
                else if (!busy_s)
                begin
                    pins_d.load_strobe_n = 1'b0;
                    cnt_d = dphw_pkg::CNT_W'(dphw_pkg::LOAD_PULSE_CYC);
                    st_d = dphw_pkg::ST_LOAD;
                end
            end
            dphw_pkg::ST_LOAD:
            begin
                if (cnt_q > 1)
                begin
                    cnt_d = cnt_q - 1'b1;
                end
                else
                begin
                    pins_d.load_strobe_n = 1'b1;
                    st_d = dphw_pkg::ST_GAP;
                end
            end
            dphw_pkg::ST_GAP:
            begin
                st_d = dphw_pkg::ST_IDLE;
            end
            default:
            begin
                st_d = dphw_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st_q <= dphw_pkg::ST_IDLE;
            cnt_q <= '0;
            cur_q <= '0;
            pins_q <= '{sel_n: 1'b1, rd_nwr: 1'b1, addr: '0, dout: dphw_pkg::DATA_RST,
                        data_oe_n: 1'b1, load_strobe_n: 1'b1};
            rsp_valid_q <= 1'b0;
            rsp_data_q <= dphw_pkg::DATA_RST;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            cur_q <= cur_d;
            pins_q <= pins_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_data_q <= rsp_data_d;
        end
    end

    assign pins_o = pins_q;
    assign rsp_valid_o = rsp_valid_q;
    assign rsp_data_o = rsp_data_q;

    // ==========================================================
    // Checks
    a_sel_dir_stable: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (!pins_q.sel_n && $past(!pins_q.sel_n)) |-> $stable(pins_q.rd_nwr))
        else $error("direction changed during select");
    a_sel_dir_setup: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        $fell(pins_q.sel_n) |-> $past(pins_q.rd_nwr) == pins_q.rd_nwr)
        else $error("direction not set up before select");
    a_read_sel_width: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ($fell(pins_q.sel_n) && pins_q.rd_nwr) |-> !pins_q.sel_n [*5])
        else $error("read select too short");
    a_write_sel_width: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ($fell(pins_q.sel_n) && !pins_q.rd_nwr) |-> !pins_q.sel_n [*2])
        else $error("write select too short");
    a_plain_no_load: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (st_q == dphw_pkg::ST_HOLD && !need_load) |-> pins_q.load_strobe_n == sync_mode_i)
        else $error("load strobe moved on plain write");
    a_async_load_low: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        // Strobe leaves its reset level one edge after release, so skip that edge
        (!sync_mode_i && $past(!sync_mode_i) && $past(arst_n_i)) |-> !pins_q.load_strobe_n)
        else $error("load strobe not low in async mode");
    a_sync_load_pulse: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (st_q == dphw_pkg::ST_HOLD && cnt_q == 1 && need_load && !correction_enable_i)
        |=> !pins_q.load_strobe_n ##1 pins_q.load_strobe_n)
        else $error("missing load pulse");
    a_busy_load_wait: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (st_q == dphw_pkg::ST_BUSY && busy_s) |=> pins_q.load_strobe_n)
        else $error("load while busy");
    a_read_bus_free: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        pins_q.rd_nwr |-> pins_q.data_oe_n)
        else $error("host drives bus during read");
    c_read: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i) rsp_valid_q);
    c_sync_load: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        st_q == dphw_pkg::ST_LOAD);
    c_busy_wait: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        st_q == dphw_pkg::ST_BUSY && busy_s);
endmodule // dphw_host

// *** rtl/dphw_pkg.sv ***
// Package for the converter parallel-port host controller
package dphw_pkg;

    // ==========================================================
    // Widths
    localparam int ADDR_W = 5;
    localparam int DATA_W = 12;

    // ==========================================================
    // Timing at 50 MHz, figures in ns
    localparam int CLK_NS = 20;
    localparam int WR_SEL_NS = 35;
    localparam int RD_SEL_NS = 60;
    localparam int DIR_SETUP_NS = 2;
    localparam int LOAD_PULSE_NS = 10;
    localparam int SEL_TO_LOAD_NS = 30;
    localparam int BUSY_FALL_NS = 20;
    localparam int WR_SEL_CYC = (WR_SEL_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_SEL_CYC = (RD_SEL_NS + CLK_NS - 1) / CLK_NS;
    localparam int DIR_SETUP_CYC = (DIR_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int LOAD_PULSE_CYC = (LOAD_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SEL_TO_LOAD_CYC = (SEL_TO_LOAD_NS + CLK_NS - 1) / CLK_NS;
    localparam int BUSY_FALL_CYC = (BUSY_FALL_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 4;

    // ==========================================================
    // Reset values
    localparam logic [DATA_W-1:0] DATA_RST = 12'h000;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DIR = 3'b001,
        ST_SEL = 3'b010,
        ST_HOLD = 3'b011,
        ST_GAP = 3'b100,
        ST_BUSY = 3'b101,
        ST_LOAD = 3'b110
    } dphw_state_t;

    typedef struct packed {
        logic read;
        logic chan_reg;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dphw_req_t;

    typedef struct packed {
        logic sel_n;
        logic rd_nwr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic data_oe_n;
        logic load_strobe_n;
    } dphw_pins_t;

endpackage

// *** rtl/dphw_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dphw_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s1_q <= '0;
            s2_q <= '0;
        end
        else
        begin
            s1_q <= d_i;
            s2_q <= s1_q;
        end
    end

    assign q_o = s2_q;
endmodule // dphw_sync

// *** sim/dphw_dev_model.sv ***
// Behavioural converter device seen through the host controller pins
`timescale 1ns/1ps
module dphw_dev_model #(
    parameter int BUSY_CYC = 6
) (
    input wire logic ref_clk_i,
    input wire dphw_pkg::dphw_pins_t pins_i,
    input wire logic correction_enable_i,
    output logic [dphw_pkg::DATA_W-1:0] data_o,
    output logic busy_o,
    output int load_cnt,
    output int bad_cnt
);
    // ==========================================================
    // Register file, one space for both channel groups
    // Channels 0-3 and 4-7 are grouped inside only; nothing shows at the pins
    logic [dphw_pkg::DATA_W-1:0] mem [32];
    logic [dphw_pkg::DATA_W-1:0] last_q = 12'hFFF;
    logic [dphw_pkg::DATA_W-1:0] bus;
    logic drive;
    logic strobe_q = 1'b1;
    assign drive = !pins_i.sel_n && pins_i.rd_nwr;
    // Released bus shows a toggling pattern, never the last value held
    assign data_o = drive ? mem[pins_i.addr] : ~last_q;
    assign bus = pins_i.data_oe_n ? data_o : pins_i.dout;
    initial
    begin
        busy_o = 1'b0;
        load_cnt = 0;
        bad_cnt = 0;
        foreach (mem[i]) mem[i] = 12'h000;
    end
    // ==========================================================
    // Bus contention and load strobe watch
    always @(posedge ref_clk_i)
    begin
        last_q <= data_o;
        strobe_q <= pins_i.load_strobe_n;
        if (drive && !pins_i.data_oe_n) bad_cnt <= bad_cnt + 1;
        if (strobe_q && !pins_i.load_strobe_n)
        begin
            load_cnt <= load_cnt + 1;
            if (busy_o) bad_cnt <= bad_cnt + 1;
        end
    end
    // ==========================================================
    // Write taken as select rises; correction then runs for a while
    always @(posedge pins_i.sel_n)
    begin
        if (!pins_i.rd_nwr) mem[pins_i.addr] <= bus;
        if (!pins_i.rd_nwr && correction_enable_i)
        begin
            busy_o = 1'b1;
            repeat (BUSY_CYC) @(posedge ref_clk_i);
            busy_o <= 1'b0;
        end
    end
endmodule // dphw_dev_model

// *** sim/tb.sv ***
// Self-checking testbench for the parallel-port host controller
`timescale 1ns/1ps
module tb;
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic req_valid_i = 1'b0;
    logic sync_mode_i = 1'b0;
    logic correction_enable_i = 1'b0;
    dphw_pkg::dphw_req_t req_i = '0;
    logic req_ready_o;
    logic rsp_valid_o;
    logic [dphw_pkg::DATA_W-1:0] rsp_data_o;
    dphw_pkg::dphw_pins_t pins_o;
    logic [dphw_pkg::DATA_W-1:0] data_i;
    logic busy_i;
    logic [dphw_pkg::DATA_W-1:0] q;
    int errors = 0;
    int cmp_count = 0;
    int load_cnt;
    int bad_cnt;
    int l;
    always #10 ref_clk_i = ~ref_clk_i;
    dphw_host dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .req_i(req_i), .sync_mode_i(sync_mode_i),
        .correction_enable_i(correction_enable_i), .rsp_valid_o(rsp_valid_o),
        .rsp_data_o(rsp_data_o), .pins_o(pins_o), .data_i(data_i), .busy_i(busy_i));
    dphw_dev_model dev (.ref_clk_i(ref_clk_i), .pins_i(pins_o),
        .correction_enable_i(correction_enable_i), .data_o(data_i), .busy_o(busy_i),
        .load_cnt(load_cnt), .bad_cnt(bad_cnt));
    // ==========================================================
    // Shared tasks
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk_d(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_n(input int got, input int exp);
        cmp_count++;
        if (got != exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One access; entered and left at a falling edge
    task automatic access(input logic rd, input logic ch, input logic [4:0] a,
        input logic [11:0] d, output logic [11:0] rq);
        int n;
        logic got;
        n = 0;
        got = 1'b0;
        rq = 12'h000;
        while (req_ready_o !== 1'b1 && n < 200)
        begin
            @(negedge ref_clk_i);
            n++;
        end
        req_i = '{read: rd, chan_reg: ch, addr: a, wdata: d};
        req_valid_i = 1'b1;
        @(negedge ref_clk_i);
        req_valid_i = 1'b0;
        while ((req_ready_o !== 1'b1 || (rd && !got)) && n < 200)
        begin
            if (rsp_valid_o === 1'b1)
            begin
                got = 1'b1;
                rq = rsp_data_o;
            end
            @(negedge ref_clk_i);
            n++;
        end
        if (n >= 200)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, n, 200);
            test_done();
        end
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_plain;
        l = load_cnt;
        access(1'b0, 1'b0, 5'h01, 12'hA5C, q);
        chk_n(load_cnt, l);
        access(1'b1, 1'b0, 5'h01, 12'h000, q);
        chk_d(q, 12'hA5C);
        $display("t_plain done");
    endtask
    task automatic t_async;
        l = load_cnt;
        access(1'b0, 1'b1, 5'h08, 12'h3C7, q);
        chk_n(load_cnt, l);
        chk_d({11'h000, pins_o.load_strobe_n}, 12'h000);
        access(1'b1, 1'b1, 5'h08, 12'h000, q);
        chk_d(q, 12'h3C7);
        $display("t_async done");
    endtask
    // Back to back over both channel groups, then read all back
    task automatic t_groups;
        for (int i = 0; i < 8; i++) access(1'b0, 1'b1, 5'h10 + 5'(i), 12'h900 + 12'(i), q);
        for (int i = 0; i < 8; i++)
        begin
            access(1'b1, 1'b1, 5'h10 + 5'(i), 12'h000, q);
            chk_d(q, 12'h900 + 12'(i));
        end
        $display("t_groups done");
    endtask
    task automatic t_sync;
        sync_mode_i = 1'b1;
        repeat (3) @(negedge ref_clk_i);
        l = load_cnt;
        access(1'b0, 1'b1, 5'h09, 12'h5A1, q);
        chk_n(load_cnt, l + 1);
        access(1'b0, 1'b0, 5'h02, 12'h0F0, q);
        chk_n(load_cnt, l + 1);
        $display("t_sync done");
    endtask
    task automatic t_corr;
        correction_enable_i = 1'b1;
        l = load_cnt;
        access(1'b0, 1'b1, 5'h0C, 12'hC3A, q);
        access(1'b0, 1'b1, 5'h0D, 12'h1E5, q);
        chk_n(load_cnt, l + 2);
        chk_n(bad_cnt, 0);
        $display("t_corr done");
    endtask
    initial
    begin
        repeat (20) @(negedge ref_clk_i);
        arst_n_i = 1'b1;
        // Let the async strobe fall after reset before any load count is taken
        repeat (3) @(negedge ref_clk_i);
        t_plain();
        t_async();
        t_groups();
        t_sync();
        t_corr();
        test_done();
    end
endmodule // tb
